// [bench/pic_link_asserts.sv]
// link protocol and interrupt gating checks
`timescale 1ns/10ps
`include "pic_params.svh"
module pic_link_asserts
(
   input wire logic CLK,           // clock
   input wire logic RST,           // synchronous reset
   input wire logic req,           // host request
   input wire logic wr,            // direction
   input wire logic [3:0] addr,    // register index
   input wire logic [31:0] wdata,  // write data
   input wire logic [31:0] rdata,  // read data
   input wire logic ack,           // answer pulse
   input wire logic irq,           // processor request
   input wire logic refused        // refusal pulse
);
   logic master_q;
   logic hw_q;
   wire taken = req && !ack;
   wire ctrl_wr = taken && wr && addr == `PIC_REG_CONTROL;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // shadow of master and mode, so gating is judged from link traffic alone
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         master_q <= 1'b0;
         hw_q <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         master_q <= wdata[`PIC_CTRL_MASTER];
         hw_q <= hw_q | wdata[`PIC_CTRL_HW_MODE];
      end
   end

   // link handshake and data
   property p_ack_answer; taken |=> ack; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("link request not answered");
   property p_ack_pulse; ack |=> !ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_cause; ack |-> $past(taken); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_rdata_idle; !ack |-> rdata == 32'h0000_0000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");
   property p_top_format;
      ack && !wr && addr == `PIC_REG_TOP |-> rdata[`PIC_TOP_VALID-1:`PIC_TOP_INDEX_W] == 26'h0;
   endproperty
   a_top_format: assert property (p_top_format) else $error("top index word has stray bits");
   // mode return refusal
   property p_refuse_fire; ctrl_wr && !wdata[`PIC_CTRL_HW_MODE] && hw_q |=> refused; endproperty
   a_refuse_fire: assert property (p_refuse_fire) else $error("mode return not refused");
   property p_refuse_cause; refused |-> hw_q && $past(ctrl_wr && !wdata[`PIC_CTRL_HW_MODE]); endproperty
   a_refuse_cause: assert property (p_refuse_cause) else $error("refusal without cause");
   // request gating: irq never stands with master clear, and falls only after a write
   property p_master_gate; !master_q |-> !irq; endproperty
   a_master_gate: assert property (p_master_gate) else $error("irq with master clear");
   property p_irq_fall; $fell(irq) |-> $past(taken && wr); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");

   c_refused: cover property (refused);
   c_irq: cover property ($rose(irq));
   c_read: cover property (ack && !wr);
endmodule : pic_link_asserts

// [bench/testbench.sv]
// self-checking bench: controller and host bridge joined by the link
`timescale 1ns/10ps
`include "pic_params.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
   import pic_pkg::*;
   localparam logic [5:0] pend_a = {`PIC_REG_PENDING, 2'b00};
   localparam logic [5:0] en_a = {`PIC_REG_ENABLE, 2'b00};
   localparam logic [5:0] ack_a = {`PIC_REG_ACK, 2'b00};
   localparam logic [5:0] ctrl_a = {`PIC_REG_CONTROL, 2'b00};
   localparam logic [5:0] edge_a = {`PIC_REG_EDGE_SEL, 2'b00};
   localparam logic [5:0] act_a = {`PIC_REG_ACTIVE, 2'b00};
   localparam logic [5:0] top_a = {`PIC_REG_TOP, 2'b00};
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] src = 8'h00;
   logic [5:0] av_addr = 6'h00;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   word_t av_wdata = 32'h0;
   word_t av_rdata;
   word_t rv;
   logic av_wait;
   logic cpu_irq;
   logic irq_out;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   logic [5:0] rst_list [6] = '{6'h00, 6'h04, 6'h0C, 6'h10, 6'h20, 6'h24};

   pic_link_if link();
   pic_controller #(.SOURCE_COUNT(8)) i_pic_controller (.CLK(CLK), .RST(RST), .SRC_IN(src), .LINK(link));
   pic_host_bridge i_pic_host_bridge (.CLK(CLK), .RST(RST), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
      .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait),
      .CPU_IRQ(cpu_irq), .IRQ_OUT(irq_out), .LINK(link));
   pic_link_asserts i_pic_link_asserts (.CLK(CLK), .RST(RST), .req(link.req), .wr(link.wr), .addr(link.addr),
      .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .irq(link.irq), .refused(link.refused));

   // clock and hang guard; the ceiling is well over fifty times the expected run
   always #4 CLK = ~CLK;
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // one avalon transfer; request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [5:0] a, input word_t d);
      @(posedge CLK);
      av_rd <= !w;
      av_wr <= w;
      av_addr <= a;
      av_wdata <= d;
      @(posedge CLK);
      #1;
      while (av_wait !== 1'b0)
      begin
         @(posedge CLK);
         #1;
      end
      rv = av_rdata;
      @(posedge CLK);
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      #1;
   endtask : bus

   task automatic chk_rd(input logic [5:0] a, input word_t e);
      bus(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rv)
   endtask : chk_rd

   // inputs change at an edge, then the synchroniser gets time to settle
   task automatic src_set(input logic [7:0] v);
      @(posedge CLK);
      src <= v;
      repeat (8) @(posedge CLK);
      #1;
   endtask : src_set

   initial
   begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      foreach (rst_list[i]) chk_rd(rst_list[i], 32'h0);
      src_set(8'hFF);
      chk_rd(pend_a, 32'h0);
      src_set(8'h00);
      bus(1'b1, pend_a, 32'h0A);
      chk_rd(pend_a, 32'h0A);
      bus(1'b1, en_a, 32'h08);
      chk_rd(en_a, 32'h08);
      chk_rd(act_a, 32'h08);
      chk_rd(top_a, 32'h8000_0003);
      `CHK("cpu irq", 1'b0, cpu_irq)
      bus(1'b1, en_a, 32'h0A);
      chk_rd(top_a, 32'h8000_0001);
      bus(1'b1, `PIC_HOST_MASK, 32'h3);
      bus(1'b1, ctrl_a, 32'h1);
      `CHK("cpu irq", 1'b1, cpu_irq)
      `CHK("irq out", 1'b1, irq_out)
      chk_rd(`PIC_HOST_STATUS, 32'h1);
      bus(1'b1, en_a, 32'h08);
      bus(1'b1, ack_a, 32'h08);
      `CHK("cpu irq", 1'b0, cpu_irq)
      chk_rd(pend_a, 32'h02);
      bus(1'b1, en_a, 32'h02);
      `CHK("cpu irq", 1'b1, cpu_irq)
      bus(1'b1, ctrl_a, 32'h0);
      `CHK("cpu irq", 1'b0, cpu_irq)
      bus(1'b1, ack_a, 32'h02);
      bus(1'b1, en_a, 32'h0);
      bus(1'b1, edge_a, 32'h01);
      bus(1'b1, ctrl_a, 32'h3);
      bus(1'b1, pend_a, 32'h80);
      chk_rd(pend_a, 32'h0);
      src_set(8'h03);
      src_set(8'h02);
      chk_rd(pend_a, 32'h03);
      bus(1'b1, ack_a, 32'h03);
      chk_rd(pend_a, 32'h02);
      src_set(8'h03);
      src_set(8'h02);
      chk_rd(pend_a, 32'h03);
      bus(1'b1, en_a, 32'h01);
      `CHK("cpu irq", 1'b1, cpu_irq)
      src_set(8'h00);
      bus(1'b1, ack_a, 32'h03);
      chk_rd(pend_a, 32'h0);
      `CHK("cpu irq", 1'b0, cpu_irq)
      bus(1'b1, `PIC_HOST_STATUS, 32'h3);
      bus(1'b1, ctrl_a, 32'h1);
      chk_rd(`PIC_HOST_STATUS, 32'h2);
      chk_rd(ctrl_a, 32'h3);
      bus(1'b1, pend_a, 32'h04);
      chk_rd(pend_a, 32'h0);
      bus(1'b1, `PIC_HOST_MASK, 32'h1);
      `CHK("irq out", 1'b0, irq_out)
      bus(1'b1, 6'h28, 32'hFFFF_FFFF);
      chk_rd(6'h28, 32'h0);
      give_verdict();
   end
endmodule : testbench

// [rtl/pic_controller.sv]
// prioritized interrupt controller, device end of the link
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`include "pic_params.svh"
module pic_controller
#(
   parameter int SOURCE_COUNT = 32
)
(
   input wire logic CLK,                          // 125 MHz clock
   input wire logic RST,                          // synchronous reset, high
   input wire logic [SOURCE_COUNT-1:0] SRC_IN,    // peripheral request lines
   pic_link_if.dev LINK                           // link to host bridge
);
   import pic_pkg::*;

   // sources at or above SOURCE_COUNT are masked everywhere, so they never pend
   // limitation: at most 32 sources, one per bit of a link word
   localparam word_t SRC_MASK = word_t'((64'h1 << SOURCE_COUNT) - 64'h1);

   // whole state of the controller end, registered in one place
   dev_state_s st;
   dev_state_s next_st;

   // lowest set index wins, as index zero is the most urgent source
   function automatic word_t top_of(input word_t act);
      word_t r;
      r = `PIC_RST_WORD;
      // scan downward so the last hit, the lowest index, is the one kept
      for (int i = 31; i >= 0; i--)
      begin
         if (act[i])
         begin
            r = `PIC_RST_WORD;
            r[`PIC_TOP_VALID] = 1'b1;
            r[`PIC_TOP_INDEX_W-1:0] = i[`PIC_TOP_INDEX_W-1:0];
         end
      end
      return r;
   endfunction : top_of

   // capture terms
   word_t rise;
   word_t hw_set;
   word_t sw_set;
   word_t clr;
   word_t active;
   // link decode strobes
   logic take;
   logic wr_take;
   logic rd_take;
   logic wr_pending;
   logic wr_enable;
   logic wr_ack;
   logic wr_control;
   logic wr_edge;
   logic back_to_sw;

   // a taken write that lands on one register index
   function automatic logic hit(input logic strobe, input link_addr_t a, input link_addr_t idx);
      return strobe && (a == idx);
   endfunction : hit

   // read view of one index; write-only and unmapped indices read as zero
   function automatic word_t read_view(input link_addr_t a, input dev_state_s s, input word_t act);
      word_t r;
      r = `PIC_RST_WORD;
      if (a == `PIC_REG_PENDING)
      begin
         r = s.pending;
      end
      else if (a == `PIC_REG_ENABLE)
      begin
         r = s.enable;
      end
      else if (a == `PIC_REG_CONTROL)
      begin
         // master reads back in bit zero, mode in bit one
         r = 32'({s.hw_mode, s.master});
      end
      else if (a == `PIC_REG_EDGE_SEL)
      begin
         r = s.edge_sel;
      end
      else if (a == `PIC_REG_ACTIVE)
      begin
         r = act;
      end
      else if (a == `PIC_REG_TOP)
      begin
         r = top_of(act);
      end
      return r;
   endfunction : read_view

   // link decode; the host holds req until ack, so the ack cycle never takes a second time
   always_comb
   begin
      take = LINK.req && !st.ack;
      wr_take = take && LINK.wr;
      rd_take = take && !LINK.wr;
      // one strobe per writable index
      wr_pending = hit(wr_take, LINK.addr, `PIC_REG_PENDING);
      wr_enable = hit(wr_take, LINK.addr, `PIC_REG_ENABLE);
      wr_ack = hit(wr_take, LINK.addr, `PIC_REG_ACK);
      wr_control = hit(wr_take, LINK.addr, `PIC_REG_CONTROL);
      wr_edge = hit(wr_take, LINK.addr, `PIC_REG_EDGE_SEL);
      // a control write with the mode bit clear asks for software trigger mode again
      back_to_sw = wr_control && !LINK.wdata[`PIC_CTRL_HW_MODE];
   end

   // capture terms from the filtered pins and from link writes
   always_comb
   begin
      // settled rise: stages two and three agree high while the filtered level is still low
      rise = (st.sync2 & st.sync3 & ~st.filt) & SRC_MASK;
      // edge sources latch on a settled rise, level sources while high
      hw_set = ((st.edge_sel & rise) | (~st.edge_sel & st.filt)) & SRC_MASK;
      // modes exclude each other: pins count only in hardware mode, writes only in software mode
      hw_set = st.hw_mode ? hw_set : `PIC_RST_WORD;

      // software trigger: a one written pends the source, a zero leaves it alone
      sw_set = (wr_pending && !st.hw_mode) ? (LINK.wdata & SRC_MASK) : `PIC_RST_WORD;
      // acknowledge is a write of ones; bits written zero stay untouched
      clr = wr_ack ? (LINK.wdata & SRC_MASK) : `PIC_RST_WORD;

      // pending and enabled together, before the master gate
      active = st.pending & st.enable;
   end

   // next state; one copy of the whole state is built here
   always_comb
   begin
      next_st = st;

      // three-stage synchroniser, a level counts once stages two and three agree
      next_st.sync1 = 32'(SRC_IN);
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      next_st.filt = (st.sync2 & st.sync3) | (st.filt & (st.sync2 | st.sync3));

      // set beats clear, so a level still high re-pends after an early ack
      next_st.pending = ((st.pending & ~clr) | hw_set | sw_set) & SRC_MASK;

      // ack answers one cycle after the take; read data stands only in that cycle
      next_st.ack = take;
      next_st.rdata = rd_take ? read_view(LINK.addr, st, active) : `PIC_RST_WORD;

      // per-source enables, written as a whole word
      if (wr_enable)
      begin
         next_st.enable = LINK.wdata & SRC_MASK;
      end
      // capture type per source, a one means edge
      if (wr_edge)
      begin
         next_st.edge_sel = LINK.wdata & SRC_MASK;
      end
      // master and mode share one register
      if (wr_control)
      begin
         next_st.master = LINK.wdata[`PIC_CTRL_MASTER];
         // hardware mode is one-way; only a reset brings software trigger mode back
         next_st.hw_mode = st.hw_mode | LINK.wdata[`PIC_CTRL_HW_MODE];
      end

      // a refused return shows for one cycle so the host can latch it as an event
      next_st.refused = back_to_sw && st.hw_mode;
      // request follows pending-and-enabled, gated by master; enable takes effect next edge
      // built from the next state so the request does not lag its cause by an extra cycle
      next_st.irq = next_st.master && (|(next_st.pending & next_st.enable));
   end

   // register the state; reset lands in software trigger mode, all disabled
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // every link output comes straight from a flip-flop
   assign LINK.rdata = st.rdata;
   assign LINK.ack = st.ack;
   assign LINK.irq = st.irq;
   assign LINK.refused = st.refused;
endmodule : pic_controller

// [rtl/pic_host_bridge.sv]
// host end: avalon-mm slave that forwards to the controller link
`timescale 1ns/10ps
`include "pic_params.svh"
module pic_host_bridge
(
   input wire logic CLK,                    // 125 MHz clock
   input wire logic RST,                    // synchronous reset, high
   input wire logic [5:0] AVS_ADDRESS,      // byte address
   input wire logic AVS_READ,               // read request
   input wire logic AVS_WRITE,              // write request
   input wire logic [31:0] AVS_WRITEDATA,   // write data
   output logic [31:0] AVS_READDATA,        // read data
   output logic AVS_WAITREQUEST,            // stall
   output logic CPU_IRQ,                    // processor request level
   output logic IRQ_OUT,                    // masked event interrupt
   pic_link_if.host LINK                    // link to controller
);
   import pic_pkg::*;

   host_state_s st;
   host_state_s next_st;
   logic [1:0] ev;
   logic [1:0] w1c;
   logic busy;

   // events and write-one-to-clear decode
   always_comb
   begin
      ev = `PIC_RST_EV;
      ev[`PIC_EV_IRQ_RISE] = LINK.irq && !st.irq_q;
      ev[`PIC_EV_REFUSED] = LINK.refused;
      w1c = `PIC_RST_EV;
      if (st.state == H_DONE && st.wr && st.addr == `PIC_HOST_STATUS >> 2)
      begin
         w1c = st.wdata[`PIC_EV_W-1:0];
      end
      busy = AVS_READ || AVS_WRITE;
   end

   // next state; link addresses go through, local ones finish here
   always_comb
   begin
      next_st = st;
      next_st.irq_q = LINK.irq;
      // a new event wins over a clear in the same cycle
      next_st.status = (st.status & ~w1c) | ev;
      case (st.state)
         H_IDLE:
         begin
            if (busy)
            begin
               next_st.wr = AVS_WRITE;
               next_st.addr = AVS_ADDRESS[5:2];
               next_st.wdata = AVS_WRITEDATA;
               next_st.readdata = `PIC_RST_WORD;
               if (AVS_ADDRESS <= `PIC_HOST_LINK_LAST)
               begin
                  next_st.state = H_LINK;
               end
               else
               begin
                  next_st.state = H_DONE;
                  if (AVS_ADDRESS == `PIC_HOST_STATUS)
                  begin
                     next_st.readdata = 32'(st.status);
                  end
                  else if (AVS_ADDRESS == `PIC_HOST_MASK)
                  begin
                     next_st.readdata = 32'(st.mask);
                  end
               end
            end
         end
         H_LINK:
         begin
            if (LINK.ack)
            begin
               next_st.readdata = LINK.rdata;
               next_st.state = H_DONE;
            end
         end
         H_DONE:
         begin
            if (st.wr && st.addr == `PIC_HOST_MASK >> 2)
            begin
               next_st.mask = st.wdata[`PIC_EV_W-1:0];
            end
            next_st.state = H_IDLE;
         end
         default:
         begin
            next_st.state = H_IDLE;
         end
      endcase
   end

   // register the state
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // waitrequest drops only in the done cycle, when read data is already registered
   assign AVS_WAITREQUEST = busy && st.state != H_DONE;
   assign AVS_READDATA = st.readdata;
   assign CPU_IRQ = st.irq_q;
   assign IRQ_OUT = |(st.status & st.mask);
   assign LINK.req = st.state == H_LINK;
   assign LINK.wr = st.wr;
   assign LINK.addr = st.addr;
   assign LINK.wdata = st.wdata;
endmodule : pic_host_bridge

// [rtl/pic_link_if.sv]
// link between the interrupt controller and its host bridge
`timescale 1ns/10ps
interface pic_link_if;
   logic req;                  // host holds until ack
   logic wr;                   // 1 write, 0 read
   logic [3:0] addr;           // register index
   logic [31:0] wdata;         // write data
   logic [31:0] rdata;         // read data, valid with ack
   logic ack;                  // one-cycle answer
   logic irq;                  // processor request level
   logic refused;              // one-cycle pulse, mode return refused

   modport dev
   (
      input req, wr, addr, wdata,
      output rdata, ack, irq, refused
   );

   modport host
   (
      output req, wr, addr, wdata,
      input rdata, ack, irq, refused
   );
endinterface : pic_link_if

// [rtl/pic_params.svh]
// constants of the prioritized interrupt controller and its host bridge
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
// link register indices of the controller end
`define PIC_REG_PENDING 4'h0
`define PIC_REG_ENABLE 4'h1
`define PIC_REG_ACK 4'h2
`define PIC_REG_CONTROL 4'h3
`define PIC_REG_EDGE_SEL 4'h4
`define PIC_REG_ACTIVE 4'h5
`define PIC_REG_TOP 4'h6
// control register fields
`define PIC_CTRL_MASTER 0
`define PIC_CTRL_HW_MODE 1
// top register fields
`define PIC_TOP_VALID 31
`define PIC_TOP_INDEX_W 5
// host local registers and the last link offset, byte offsets on the avalon side
`define PIC_HOST_STATUS 6'h20
`define PIC_HOST_MASK 6'h24
`define PIC_HOST_LINK_LAST 6'h18
// host status fields
`define PIC_EV_IRQ_RISE 0
`define PIC_EV_REFUSED 1
`define PIC_EV_W 2
// reset values
`define PIC_RST_WORD 32'h0000_0000
`define PIC_RST_EV 2'h0
`endif

// [rtl/pic_pkg.sv]
// types shared by both ends of the interrupt controller
package pic_pkg;
   typedef logic [31:0] word_t;
   typedef logic [3:0] link_addr_t;

   typedef enum logic [1:0]
   {
      H_IDLE = 2'b00,
      H_LINK = 2'b01,
      H_DONE = 2'b10
   } host_state_e;

   typedef struct packed
   {
      word_t sync1;
      word_t sync2;
      word_t sync3;
      word_t filt;
      word_t pending;
      word_t enable;
      word_t edge_sel;
      logic master;
      logic hw_mode;
      logic ack;
      logic refused;
      logic irq;
      word_t rdata;
   } dev_state_s;

   typedef struct packed
   {
      host_state_e state;
      logic wr;
      link_addr_t addr;
      word_t wdata;
      word_t readdata;
      logic irq_q;
      logic [1:0] status;
      logic [1:0] mask;
   } host_state_s;
endpackage : pic_pkg
